// ===== design/usart_pkg.sv
/*
 Shared constants of the serial port block: register byte offsets,
 field positions, reset values, oversampling divisors, state codes.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package usart_pkg;
	// ************************************************
	// Register offsets (byte addresses, one word each)
	// ************************************************
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_FMT = 8'h0c;
	localparam logic [7:0] ADDR_BAUDL = 8'h10;
	// ************************************************
	// Field positions
	// ************************************************
	localparam int STAT_RXDONE = 7;
	localparam int STAT_TXDONE = 6;
	localparam int STAT_EMPTY = 5;
	localparam int STAT_DOUBLE = 1;
	localparam int STAT_FILTER = 0;
	localparam int CTRL_RXIE = 7;
	localparam int CTRL_TXIE = 6;
	localparam int CTRL_EMPTYIE = 5;
	localparam int CTRL_RXON = 4;
	localparam int CTRL_TXON = 3;
	localparam int CTRL_LENHI = 2;
	localparam int CTRL_TXNINTH = 0;
	localparam int FMT_SEL = 7;
	localparam int FMT_MODE = 6;
	localparam int FMT_PARHI = 5;
	localparam int FMT_PARLO = 4;
	localparam int FMT_STOP = 3;
	// ************************************************
	// Reset values and rates
	// ************************************************
	localparam logic [6:0] FMT_RESET = 7'h00;
	localparam logic [11:0] BAUD_RESET = 12'h000;
	localparam logic [4:0] OSR_NORMAL = 5'h10;
	localparam logic [4:0] OSR_DOUBLE = 5'h08;
	// ************************************************
	// State codes
	// ************************************************
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_BITS = 3'b100
	} rx_state_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_t;
	// Reserved size codes fall back to eight bits
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		case (code)
			3'h0: char_bits = 4'h5;
			3'h1: char_bits = 4'h6;
			3'h2: char_bits = 4'h7;
			3'h7: char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== design/usart_tx_shifter.sv
/*
 Transmit shift register: builds start, data, parity and stop bits
 and shifts them out LSB first.
 Assumes one oversample tick from the parent's baud divider.
*/
`timescale 1ns/1ps
`default_nettype none
module usart_tx_shifter (
	input wire logic clk,
	input wire logic srst,
	input wire logic tick,
	input wire logic [4:0] osr,
	input wire logic load,
	input wire logic [8:0] data,
	input wire logic [3:0] nbits,
	input wire logic parEn,
	input wire logic parOdd,
	input wire logic twoStop,
	output logic busy,
	output logic done,
	output logic txd
);
	usart_pkg::tx_state_t state_ff;
	logic [12:0] shift_ff;
	logic [12:0] frm;
	logic [3:0] left_ff;
	logic [4:0] tickCnt_ff;
	logic par;
	// ************************************************
	// Frame assembly
	// ************************************************
	always_comb begin
		frm = '1;
		frm[0] = 1'b0;
		par = parOdd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nbits) begin
				frm[i + 1] = data[i];
				par = par ^ data[i];
			end
		end
		if (parEn) begin
			frm[nbits + 4'h1] = par;
		end
	end
	assign busy = (state_ff == usart_pkg::TX_SHIFT);
	// ************************************************
	// Shifter
	// ************************************************
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (srst) begin
			state_ff <= usart_pkg::TX_IDLE;
			shift_ff <= '1;
			left_ff <= 4'h0;
			tickCnt_ff <= 5'h00;
			txd <= 1'b1;
		end else begin
			unique case (state_ff)
				usart_pkg::TX_IDLE: begin
					txd <= 1'b1;
					if (load) begin
						shift_ff <= frm;
						txd <= 1'b0;
						tickCnt_ff <= 5'h00;
						left_ff <= nbits + {3'h0, parEn} + 4'h2 + {3'h0, twoStop};
						state_ff <= usart_pkg::TX_SHIFT;
					end
				end
				usart_pkg::TX_SHIFT: begin
					if (tick && tickCnt_ff == osr - 5'h01) begin
						tickCnt_ff <= 5'h00;
						if (left_ff == 4'h1) begin
							done <= 1'b1;
							txd <= 1'b1;
							state_ff <= usart_pkg::TX_IDLE;
						end else begin
							shift_ff <= {1'b1, shift_ff[12:1]};
							txd <= shift_ff[1];
							left_ff <= left_ff - 4'h1;
						end
					end else if (tick) begin
						tickCnt_ff <= tickCnt_ff + 5'h01;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== design/usart_rx_sampler.sv
/*
 Receive sampler: finds the start bit, samples each bit mid-cell
 and reports one finished character with its checks.
 Assumes rxd is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module usart_rx_sampler (
	input wire logic clk,
	input wire logic srst,
	input wire logic en,
	input wire logic tick,
	input wire logic [4:0] osr,
	input wire logic rxd,
	input wire logic [3:0] nbits,
	input wire logic parEn,
	input wire logic parOdd,
	output logic startSeen,
	output logic done,
	output logic [8:0] data,
	output logic stopBit,
	output logic parErr
);
	usart_pkg::rx_state_t state_ff;
	logic [4:0] tickCnt_ff;
	logic [3:0] idx_ff;
	logic [10:0] raw_ff;
	logic [10:0] nxtRaw;
	logic [3:0] need;
	logic [8:0] nxtData;
	logic nxtPar;
	// ************************************************
	// Character extraction
	// ************************************************
	always_comb begin
		need = nbits + {3'h0, parEn} + 4'h1;
		nxtRaw = raw_ff;
		nxtRaw[idx_ff] = rxd;
		nxtPar = parOdd;
		for (int i = 0; i < 9; i++) begin
			nxtData[i] = (4'(i) < nbits) ? nxtRaw[i] : 1'b0;
			nxtPar = nxtPar ^ nxtData[i];
		end
	end
	assign startSeen = en && state_ff == usart_pkg::RX_IDLE && !rxd;
	// ************************************************
	// Sampler
	// ************************************************
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (srst || !en) begin
			state_ff <= usart_pkg::RX_IDLE;
			tickCnt_ff <= 5'h00;
			idx_ff <= 4'h0;
			raw_ff <= '0;
			data <= '0;
			stopBit <= 1'b1;
			parErr <= 1'b0;
		end else begin
			unique case (state_ff)
				usart_pkg::RX_IDLE: begin
					tickCnt_ff <= 5'h00;
					if (!rxd) begin
						state_ff <= usart_pkg::RX_START;
					end
				end
				usart_pkg::RX_START: begin
					if (tick && tickCnt_ff == (osr >> 1) - 5'h01) begin
						tickCnt_ff <= 5'h00;
						idx_ff <= 4'h0;
						state_ff <= rxd ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
					end else if (tick) begin
						tickCnt_ff <= tickCnt_ff + 5'h01;
					end
				end
				usart_pkg::RX_BITS: begin
					if (tick && tickCnt_ff == osr - 5'h01) begin
						tickCnt_ff <= 5'h00;
						raw_ff <= nxtRaw;
						idx_ff <= idx_ff + 4'h1;
						if (idx_ff == need - 4'h1) begin
							done <= 1'b1;
							data <= nxtData;
							stopBit <= nxtRaw[need - 4'h1];
							parErr <= parEn && (nxtPar != nxtRaw[nbits]);
							state_ff <= usart_pkg::RX_IDLE;
						end
					end else if (tick) begin
						tickCnt_ff <= tickCnt_ff + 5'h01;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== design/async_usart_control_status.sv
/*
 Serial port control and status: AHB-Lite register slave, two-entry
 receive buffer, transmit buffer, baud divider, pin ownership.
 Assumes one clock, a synchronous reset and an external global
 interrupt enable from the processor status word.
*/
// Functional notes
// - Receive-done reads one while unread characters remain buffered.
// - Turning the receiver off discards buffered characters.
// - Transmit-done sets when the frame left and buffer empty; ack or write-one clears.
// - Buffer-empty reads one while the buffer can take a character; one after reset.
// - Stop error shows the head character's first stop bit was zero.
// - Overflow sets on start bit while buffer full and shifter holds one.
// - Parity mismatch shows the head character failed an enabled check.
// - Double speed in async mode divides by 8 instead of 16.
// - Address filter mode drops frames without address marking; transmitter unchanged.
// - Each interrupt needs its enable, the global flag and its status flag.
// - Enabled receiver owns the input pin; disabling flushes data and errors.
// - Enabled transmitter owns output pin; release only after all data sent.
// - Character length joins the high size bit with two low size bits.
// - Received ninth bit is readable separately, read before low bits.
// - Written ninth bit goes out as ninth data bit; write it first.
// - Format location shares with baud high; select bit reads one, writes pick.
// - Mode select zero is asynchronous, one synchronous; here one only turns off double speed, frames stay asynchronous.
// - Parity 00 off, 01 reserved, 10 even, 11 odd.
// - Stop select gives one or two transmitted stop bits; receiver ignores it.
// - Size codes 0..3 give five to eight bits, 7 nine; rest reserved.
// - Data writes while buffer-empty is clear are dropped.
// - Short characters ignore upper bits on send, return zeros on receive.
`timescale 1ns/1ps
`default_nettype none
module async_usart_control_status (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic globalIrqEnable,
	input wire logic txDoneIrqAck,
	input wire logic rxdPin,
	output logic txdOut,
	output logic txdOe,
	output logic rxOwnsPin,
	output logic rxDoneIrq,
	output logic txDoneIrq,
	output logic txEmptyIrq
);
	// ************************************************
	// Declarations
	// ************************************************
	logic wrPhase_ff;
	logic rdWait_ff;
	logic [7:0] addr_ff;
	logic accept;
	logic wrEn;
	logic [7:0] rdMux;
	logic dataRead;
	logic doubleSpeed_ff;
	logic addrFilter_ff;
	logic txDone_ff;
	logic overflow_ff;
	logic rxIrqEn_ff;
	logic txIrqEn_ff;
	logic emptyIrqEn_ff;
	logic rxOn_ff;
	logic txOn_ff;
	logic lenHigh_ff;
	logic txNinth_ff;
	logic [6:0] fmt_ff;
	logic [11:0] baud_ff;
	logic [11:0] baudCnt_ff;
	logic tick;
	logic [4:0] osr;
	logic [3:0] nbits;
	logic parEn;
	logic parOdd;
	logic rxS1_ff;
	logic rxS2_ff;
	logic rxS3_ff;
	logic rxLevel_ff;
	logic rxStart;
	logic rxDone;
	logic [8:0] rxData;
	logic rxStop;
	logic rxParErr;
	logic [10:0] rxWord;
	logic typeBit;
	logic acceptNew;
	logic [10:0] fifoMem [2];
	logic wrPtr_ff;
	logic rdPtr_ff;
	logic [1:0] count_ff;
	logic pendValid_ff;
	logic [10:0] pendWord_ff;
	logic [10:0] head;
	logic rxAvail;
	logic pop;
	logic room;
	logic doPush;
	logic [10:0] pushWord;
	logic [8:0] txBuf_ff;
	logic txBufValid_ff;
	logic txOwn_ff;
	logic txLoad;
	logic txBusy;
	logic txShiftDone;
	logic txLine;
	// ************************************************
	// Bus slave
	// ************************************************
	assign accept = hsel && htrans[1] && hready;
	assign wrEn = wrPhase_ff;
	assign hreadyout = !rdWait_ff;
	assign hresp = 1'b0;
	always_ff @(posedge clk) begin
		if (srst) begin
			wrPhase_ff <= 1'b0;
			rdWait_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			wrPhase_ff <= accept && hwrite;
			rdWait_ff <= accept && !hwrite;
			if (accept) begin
				addr_ff <= {haddr[7:2], 2'h0};
			end
		end
	end
	always_comb begin
		unique case (addr_ff)
			usart_pkg::ADDR_DATA: rdMux = rxAvail ? head[7:0] : 8'h00;
			usart_pkg::ADDR_STAT: rdMux = {rxAvail, txDone_ff,
				!txBufValid_ff, rxAvail && head[9], overflow_ff,
				rxAvail && head[10], doubleSpeed_ff, addrFilter_ff};
			usart_pkg::ADDR_CTRL: rdMux = {rxIrqEn_ff, txIrqEn_ff,
				emptyIrqEn_ff, rxOn_ff, txOn_ff, lenHigh_ff,
				rxAvail && head[8], txNinth_ff};
			usart_pkg::ADDR_FMT: rdMux = {1'b1, fmt_ff};
			usart_pkg::ADDR_BAUDL: rdMux = baud_ff[7:0];
			default: rdMux = 8'h00;
		endcase
	end
	assign dataRead = rdWait_ff && addr_ff == usart_pkg::ADDR_DATA;
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (rdWait_ff) begin
			hrdata <= {24'h00_0000, rdMux};
		end
	end
	// ************************************************
	// Control and format registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			doubleSpeed_ff <= 1'b0;
			addrFilter_ff <= 1'b0;
		end else if (wrEn && addr_ff == usart_pkg::ADDR_STAT) begin
			doubleSpeed_ff <= hwdata[usart_pkg::STAT_DOUBLE];
			addrFilter_ff <= hwdata[usart_pkg::STAT_FILTER];
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			rxIrqEn_ff <= 1'b0;
			txIrqEn_ff <= 1'b0;
			emptyIrqEn_ff <= 1'b0;
			rxOn_ff <= 1'b0;
			txOn_ff <= 1'b0;
			lenHigh_ff <= 1'b0;
			txNinth_ff <= 1'b0;
		end else if (wrEn && addr_ff == usart_pkg::ADDR_CTRL) begin
			rxIrqEn_ff <= hwdata[usart_pkg::CTRL_RXIE];
			txIrqEn_ff <= hwdata[usart_pkg::CTRL_TXIE];
			emptyIrqEn_ff <= hwdata[usart_pkg::CTRL_EMPTYIE];
			rxOn_ff <= hwdata[usart_pkg::CTRL_RXON];
			txOn_ff <= hwdata[usart_pkg::CTRL_TXON];
			lenHigh_ff <= hwdata[usart_pkg::CTRL_LENHI];
			txNinth_ff <= hwdata[usart_pkg::CTRL_TXNINTH];
		end
	end
	// Shared location: select bit steers the write
	always_ff @(posedge clk) begin
		if (srst) begin
			fmt_ff <= usart_pkg::FMT_RESET;
			baud_ff <= usart_pkg::BAUD_RESET;
		end else if (wrEn && addr_ff == usart_pkg::ADDR_FMT) begin
			if (hwdata[usart_pkg::FMT_SEL]) begin
				fmt_ff <= hwdata[6:0];
			end else begin
				baud_ff[11:8] <= hwdata[3:0];
			end
		end else if (wrEn && addr_ff == usart_pkg::ADDR_BAUDL) begin
			baud_ff[7:0] <= hwdata[7:0];
		end
	end
	// ************************************************
	// Frame format decode
	// ************************************************
	assign nbits = usart_pkg::char_bits({lenHigh_ff, fmt_ff[2:1]});
	assign parEn = fmt_ff[usart_pkg::FMT_PARHI];
	assign parOdd = fmt_ff[usart_pkg::FMT_PARLO];
	// Double speed only counts in asynchronous mode
	assign osr = (doubleSpeed_ff && !fmt_ff[usart_pkg::FMT_MODE]) ?
		usart_pkg::OSR_DOUBLE : usart_pkg::OSR_NORMAL;
	// ************************************************
	// Baud divider
	// ************************************************
	assign tick = (baudCnt_ff == 12'h000);
	always_ff @(posedge clk) begin
		if (srst) begin
			baudCnt_ff <= 12'h000;
		end else if (tick) begin
			baudCnt_ff <= baud_ff;
		end else begin
			baudCnt_ff <= baudCnt_ff - 12'h001;
		end
	end
	// ************************************************
	// Input pin synchroniser
	// ************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			rxS1_ff <= 1'b1;
			rxS2_ff <= 1'b1;
			rxS3_ff <= 1'b1;
			rxLevel_ff <= 1'b1;
		end else begin
			rxS1_ff <= rxdPin;
			rxS2_ff <= rxS1_ff;
			rxS3_ff <= rxS2_ff;
			if (rxS2_ff == rxS3_ff) begin
				rxLevel_ff <= rxS2_ff;
			end
		end
	end
	assign rxOwnsPin = rxOn_ff;
	// ************************************************
	// Receiver
	// ************************************************
	usart_rx_sampler rxUnit (
		.clk(clk),
		.srst(srst),
		.en(rxOn_ff),
		.tick(tick),
		.osr(osr),
		.rxd(rxLevel_ff),
		.nbits(nbits),
		.parEn(parEn),
		.parOdd(parOdd),
		.startSeen(rxStart),
		.done(rxDone),
		.data(rxData),
		.stopBit(rxStop),
		.parErr(rxParErr)
	);
	assign rxWord = {rxParErr, !rxStop, rxData};
	assign typeBit = (nbits == 4'h9) ? rxData[8] : rxStop;
	assign acceptNew = rxDone && !(addrFilter_ff && !typeBit);
	// ************************************************
	// Receive buffer, two entries plus the shifter
	// ************************************************
	assign head = fifoMem[rdPtr_ff];
	assign rxAvail = (count_ff != 2'h0);
	assign pop = dataRead && rxAvail;
	assign room = (count_ff != 2'h2) || pop;
	assign pushWord = pendValid_ff ? pendWord_ff : rxWord;
	assign doPush = (pendValid_ff || acceptNew) && room;
	always_ff @(posedge clk) begin
		if (srst) begin
			fifoMem[0] <= '0;
			fifoMem[1] <= '0;
		end else if (doPush) begin
			fifoMem[wrPtr_ff] <= pushWord;
		end
	end
	always_ff @(posedge clk) begin
		if (srst || !rxOn_ff) begin
			wrPtr_ff <= 1'b0;
			rdPtr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			wrPtr_ff <= wrPtr_ff ^ doPush;
			rdPtr_ff <= rdPtr_ff ^ pop;
			count_ff <= count_ff + {1'b0, doPush} - {1'b0, pop};
		end
	end
	// A finished character waits here while the buffer is full
	always_ff @(posedge clk) begin
		if (srst || !rxOn_ff) begin
			pendValid_ff <= 1'b0;
			pendWord_ff <= '0;
		end else if (pendValid_ff && doPush && acceptNew) begin
			pendWord_ff <= rxWord;
		end else if (pendValid_ff && doPush) begin
			pendValid_ff <= 1'b0;
		end else if (!pendValid_ff && acceptNew && !room) begin
			pendValid_ff <= 1'b1;
			pendWord_ff <= rxWord;
		end
	end
	// Set wins over the clear by a data read
	always_ff @(posedge clk) begin
		if (srst || !rxOn_ff) begin
			overflow_ff <= 1'b0;
		end else if (rxStart && count_ff == 2'h2 && pendValid_ff) begin
			overflow_ff <= 1'b1;
		end else if (pop) begin
			overflow_ff <= 1'b0;
		end
	end
	// ************************************************
	// Transmit buffer and pin ownership
	// ************************************************
	assign txLoad = txOwn_ff && txBufValid_ff && !txBusy;
	always_ff @(posedge clk) begin
		if (srst) begin
			txBufValid_ff <= 1'b0;
			txBuf_ff <= '0;
		end else if (wrEn && addr_ff == usart_pkg::ADDR_DATA &&
			!txBufValid_ff) begin
			txBufValid_ff <= 1'b1;
			txBuf_ff <= {txNinth_ff, hwdata[7:0]};
		end else if (txLoad) begin
			txBufValid_ff <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			txOwn_ff <= 1'b0;
		end else if (txOn_ff) begin
			txOwn_ff <= 1'b1;
		end else if (!txBusy && !txBufValid_ff) begin
			txOwn_ff <= 1'b0;
		end
	end
	usart_tx_shifter txUnit (
		.clk(clk),
		.srst(srst),
		.tick(tick),
		.osr(osr),
		.load(txLoad),
		.data(txBuf_ff),
		.nbits(nbits),
		.parEn(parEn),
		.parOdd(parOdd),
		.twoStop(fmt_ff[usart_pkg::FMT_STOP]),
		.busy(txBusy),
		.done(txShiftDone),
		.txd(txLine)
	);
	assign txdOut = txLine;
	assign txdOe = txOwn_ff;
	// Set wins over the acknowledge and the write-one clear
	always_ff @(posedge clk) begin
		if (srst) begin
			txDone_ff <= 1'b0;
		end else if (txShiftDone && !txBufValid_ff) begin
			txDone_ff <= 1'b1;
		end else if (txDoneIrqAck || (wrEn &&
			addr_ff == usart_pkg::ADDR_STAT &&
			hwdata[usart_pkg::STAT_TXDONE])) begin
			txDone_ff <= 1'b0;
		end
	end
	// ************************************************
	// Interrupt requests
	// ************************************************
	assign rxDoneIrq = globalIrqEnable && rxIrqEn_ff && rxAvail;
	assign txDoneIrq = globalIrqEnable && txIrqEn_ff && txDone_ff;
	assign txEmptyIrq = globalIrqEnable && emptyIrqEn_ff &&
		!txBufValid_ff;
endmodule
`default_nettype wire

// ===== verification/usart_monitor.sv
/*
 Checker of the serial block's bus, interrupt and pin timing.
 Assumes it is bound to the top module; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module usart_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic globalIrqEnable,
	input wire logic txDoneIrqAck,
	input wire logic txdOut,
	input wire logic txdOe,
	input wire logic rxOwnsPin,
	input wire logic rxDoneIrq,
	input wire logic txDoneIrq,
	input wire logic txEmptyIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic take, rdFmt, wrCtl;
	assign take = hsel && htrans[1] && hready;
	assign rdFmt = take && !hwrite && haddr[7:0] == usart_pkg::ADDR_FMT;
	assign wrCtl = take && hwrite && haddr[7:0] == usart_pkg::ADDR_CTRL;
	a_irq_gate: assert property (
		!globalIrqEnable |-> !(rxDoneIrq || txDoneIrq || txEmptyIrq))
		else $error("interrupt without global enable");
	a_ack_clears: assert property (
		txDoneIrqAck && txDoneIrq |=> !txDoneIrq)
		else $error("transmit done not cleared by service");
	a_fmt_select: assert property (
		rdFmt |=> ##1 hrdata[7])
		else $error("format select bit read as zero");
	a_rx_own_on: assert property (
		wrCtl ##1 hwdata[4] |-> ##[1:2] rxOwnsPin)
		else $error("receiver did not take input pin");
	a_rx_own_off: assert property (
		wrCtl ##1 !hwdata[4] |-> ##[1:2] !rxOwnsPin)
		else $error("receiver kept input pin");
	a_idle_high: assert property (
		!txdOe |-> txdOut)
		else $error("output low while not driven");
	a_release_idle: assert property (
		$fell(txdOe) |-> $past(txdOut) && txdOut)
		else $error("output pin released mid frame");
	a_start_cell: assert property (
		$fell(txdOut) |-> !txdOut [*8])
		else $error("start bit too short");
endmodule
bind async_usart_control_status usart_monitor MON (.clk(clk),
	.srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.globalIrqEnable(globalIrqEnable), .txDoneIrqAck(txDoneIrqAck),
	.txdOut(txdOut), .txdOe(txdOe), .rxOwnsPin(rxOwnsPin),
	.rxDoneIrq(rxDoneIrq), .txDoneIrq(txDoneIrq),
	.txEmptyIrq(txEmptyIrq));
`default_nettype wire

// ===== verification/serial_peer.sv
/*
 Remote serial peer: sends frames on the receive line and captures
 frames from the transmit line. Bit time, size and parity are set
 by the bench before use.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input wire logic clk,
	input wire logic txdOut,
	input wire logic txdOe,
	output logic rxd
);
	int bt = 16;
	int nb = 8;
	logic [1:0] par = 2'b00;
	logic [8:0] got[$];
	initial rxd = 1'b1;
	task automatic send(input logic [8:0] d, input logic badPar,
		input logic stp);
		rxd <= 1'b0;
		repeat (bt) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			rxd <= d[i];
			repeat (bt) @(posedge clk);
		end
		if (par[1]) begin
			rxd <= ^(d & ~(9'h1ff << nb)) ^ par[0] ^ badPar;
			repeat (bt) @(posedge clk);
		end
		rxd <= stp;
		repeat (bt) @(posedge clk);
		rxd <= 1'b1;
		repeat (bt) @(posedge clk);
	endtask
	// Samples mid cell; a low stop bit spoils the captured word
	always begin
		logic [8:0] v;
		@(negedge txdOut);
		if (txdOe) begin
			v = '0;
			repeat (bt / 2) @(posedge clk);
			for (int i = 0; i < nb; i++) begin
				repeat (bt) @(posedge clk);
				v[i] = txdOut;
			end
			repeat (par[1] ? 2 * bt : bt) @(posedge clk);
			if (txdOut !== 1'b1)
				v = 'x;
			got.push_back(v);
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
 Self-checking bench of the serial control and status block.
 Assumes the checker is bound and the peer model is compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] DA = usart_pkg::ADDR_DATA;
	localparam logic [7:0] ST = usart_pkg::ADDR_STAT;
	localparam logic [7:0] CT = usart_pkg::ADDR_CTRL;
	localparam logic [7:0] FM = usart_pkg::ADDR_FMT;
	logic clk, srst, hsel, hwrite, globalIrqEnable, txDoneIrqAck;
	logic hreadyout, hresp, txdOut, txdOe, rxOwnsPin, rxdPin;
	logic rxDoneIrq, txDoneIrq, txEmptyIrq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] r, b [4];
	int seed, error_cnt, cmp_count, i, m;
	async_usart_control_status DUT (.clk(clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .globalIrqEnable(globalIrqEnable),
		.txDoneIrqAck(txDoneIrqAck), .rxdPin(rxdPin), .txdOut(txdOut),
		.txdOe(txdOe), .rxOwnsPin(rxOwnsPin), .rxDoneIrq(rxDoneIrq),
		.txDoneIrq(txDoneIrq), .txEmptyIrq(txEmptyIrq));
	serial_peer peer (.clk(clk), .txdOut(txdOut), .txdOe(txdOe),
		.rxd(rxdPin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [8:0] g, input logic [8:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask
	task results;
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One single transfer; starts and ends right after a rising edge
	task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 99) begin
			@(posedge clk);
			n++;
		end
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 99) begin
			@(posedge clk);
			n++;
		end
		r = hrdata[7:0];
		chk({8'h0, hresp}, 9'h0);
		if (n >= 99) begin
			chk(9'h0, 9'h1);
			results;
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk({1'b0, r}, {1'b0, e});
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask
	task waitst(input int k, input logic v);
		int n;
		for (n = 0; n < 300; n++) begin
			bus(ST, 1'b0, 8'h00);
			if (r[k] === v)
				break;
		end
		if (n == 300) begin
			chk(9'h0, 9'h1);
			results;
		end
	endtask
	task waitrx(input int c);
		for (int n = 0; n < 3000 && peer.got.size() < c; n++)
			@(posedge clk);
		chk(9'(peer.got.size()), 9'(c));
	endtask
	initial begin
		seed = 78259;
		error_cnt = 0;
		cmp_count = 0;
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		globalIrqEnable = 1'b0;
		txDoneIrqAck = 1'b0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(ST, 8'h20);
		rd(FM, 8'h80);
		rd(CT, 8'h00);
		rd(8'h14, 8'h00);
		wr(CT, 8'hf8);
		wr(FM, 8'h86);
		globalIrqEnable <= 1'b1;
		@(posedge clk);
		chk({8'h0, txEmptyIrq}, 9'h1);
		for (i = 0; i < 3; i++) begin
			b[i] = 8'($random(seed));
			wr(DA, b[i]);
		end
		waitst(6, 1'b1);
		chk(9'(peer.got.size()), 9'h2);
		chk({8'h0, txDoneIrq}, 9'h1);
		chk(peer.got[0], {1'b0, b[0]});
		chk(peer.got[1], {1'b0, b[1]});
		txDoneIrqAck <= 1'b1;
		@(posedge clk);
		txDoneIrqAck <= 1'b0;
		rd(ST, 8'h20);
		wr(DA, b[2]);
		waitst(6, 1'b1);
		wr(ST, 8'h40);
		rd(ST, 8'h20);
		chk(peer.got[2], {1'b0, b[2]});
		for (i = 0; i < 3; i++) begin
			b[0] = 8'($random(seed));
			peer.send({1'b0, b[0]}, 1'b0, 1'b1);
			waitst(7, 1'b1);
			chk({8'h0, rxDoneIrq}, 9'h1);
			rd(DA, b[0]);
			rd(ST, 8'h20);
		end
		peer.send(9'h05a, 1'b0, 1'b0);
		waitst(7, 1'b1);
		rd(ST, 8'hb0);
		rd(DA, 8'h5a);
		rd(ST, 8'h20);
		for (m = 2; m < 4; m++) begin
			wr(FM, 8'h86 | 8'(m << 4));
			peer.par = 2'(m);
			peer.send(9'h0c3, 1'b1, 1'b1);
			waitst(7, 1'b1);
			rd(ST, 8'ha4);
			rd(DA, 8'hc3);
			peer.send(9'h0c3, 1'b0, 1'b1);
			waitst(7, 1'b1);
			rd(ST, 8'ha0);
			rd(DA, 8'hc3);
		end
		wr(FM, 8'h86);
		peer.par = 2'b00;
		for (i = 0; i < 4; i++) begin
			b[i] = 8'($random(seed));
			peer.send({1'b0, b[i]}, 1'b0, 1'b1);
		end
		rd(ST, 8'ha8);
		rd(DA, b[0]);
		rd(ST, 8'ha0);
		wr(CT, 8'he8);
		rd(ST, 8'h20);
		chk({8'h0, rxOwnsPin}, 9'h0);
		wr(CT, 8'hf8);
		for (m = 0; m < 4; m++) begin
			wr(FM, 8'h80 | 8'(m << 1));
			peer.nb = m + 5;
			peer.send(9'h1ff, 1'b0, 1'b1);
			waitst(7, 1'b1);
			rd(DA, 8'(9'h1ff >> (4 - m)));
			wr(DA, 8'hff);
			waitrx(4 + m);
			chk(peer.got[3 + m], 9'h1ff >> (4 - m));
		end
		wr(CT, 8'hfd);
		wr(FM, 8'h8e);
		peer.nb = 9;
		b[0] = 8'($random(seed));
		wr(DA, b[0]);
		wr(ST, 8'h40);
		waitrx(8);
		repeat (8) @(posedge clk);
		rd(ST, 8'h20);
		repeat (16) @(posedge clk);
		rd(ST, 8'h60);
		chk(peer.got[7], {1'b1, b[0]});
		peer.send({1'b1, b[1]}, 1'b0, 1'b1);
		waitst(7, 1'b1);
		rd(CT, 8'hff);
		rd(DA, b[1]);
		wr(ST, 8'h01);
		peer.send({1'b0, ~b[3]}, 1'b0, 1'b1);
		peer.send({1'b1, b[3]}, 1'b0, 1'b1);
		waitst(7, 1'b1);
		rd(DA, b[3]);
		wr(ST, 8'h02);
		wr(CT, 8'hf8);
		peer.nb = 8;
		peer.bt = 8;
		b[0] = 8'($random(seed));
		wr(DA, b[0]);
		waitrx(9);
		chk(peer.got[8], {1'b0, b[0]});
		peer.send({1'b0, b[1]}, 1'b0, 1'b1);
		waitst(7, 1'b1);
		rd(DA, b[1]);
		wr(FM, 8'hc6);
		peer.bt = 16;
		wr(DA, b[2]);
		wr(CT, 8'h00);
		waitrx(10);
		chk(peer.got[9], {1'b0, b[2]});
		repeat (20) @(posedge clk);
		chk({8'h0, txdOe}, 9'h0);
		results;
	end
endmodule
`default_nettype wire
